/* hdl/ser_defs.svh */
// error code values, field positions and limits for the system error reporter
// assumes nothing beyond a single clock domain
`ifndef SER_DEFS_SVH
`define SER_DEFS_SVH
`define SER_CODE_SETUP 16'h000B
`define SER_CODE_DATA 16'h000C
`define SER_CODE_LOG 16'h000D
`define SER_CODE_RD_SYNTAX 16'h000E
`define SER_CODE_WR_SYNTAX 16'h000F
`define SER_CODE_WR_DATA 16'h0010
`define SER_CODE_FLASH 16'h0011
`define SER_CODE_EEPROM 16'h0012
`define SER_CODE_NONE 16'h0000
`define SER_UNIT_MASK 2'h3
`define SER_FLAG_BIT 14
`define SER_LOG_CLR_CYCLES 1
`endif

/* hdl/ser_pkg.sv */
// types shared by the system error reporter
// assumes ser_defs.svh is compiled alongside
`default_nettype none
package ser_pkg;
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] count;
  } ser_xfer_t;
  typedef struct packed {
    logic flag;
    logic [15:0] code;
  } ser_status_t;
  typedef enum logic [1:0] {SER_IDLE, SER_CHECK, SER_INIT} ser_log_state_t;
endpackage
`default_nettype wire

/* hdl/ser_log_mem.sv */
// small error-log memory with registered read data and one write port
// assumes one clock; clear takes one entry per cycle
`default_nettype none
module ser_log_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [15:0] rd_data_o
);
  logic [15:0] mem [DEPTH];

  always_ff @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= 16'h0000;
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end
endmodule // ser_log_mem
`default_nettype wire

/* hdl/ser_reporter.sv */
// system error reporter: detects faults, holds a hex error code, demands decel stop
// assumes fault inputs are one-cycle pulses synchronous to sys_clk_i
//
// Summary of operation
// RL1: a download of new unit or machine parameters reports code 000B and stops.
// RL2: after reset of the setup error, the old parameters stay active until power cycles.
// RL3: corrupted position data from a bulk read reports 000C, stops, and clears by reset.
// RL4: at power-on a corrupted error log reports 000D and stops.
// RL5: a corrupted error log is wiped of every record automatically.
// RL6: a bulk read with bad address, bad count or count not in 4-byte units reports 000E.
// RL7: a bulk write with bad address, bad count or count not in 4-byte units reports 000F.
// RL8: the host must give a bulk write count matching the parameter size.
// RL9: a bulk write value out of range reports 0010 and stops.
// RL10: a failed flash save reports 0011 and stops.
// RL11: the flash error clears when a later flash write completes normally.
// RL12: a failed error-log EEPROM write reports 0012 and stops.
// RL13: any error sets the error flag; the first one while the flag is clear puts its hex code in the status word.
// RL14: a reported code stays held until error reset or power cycle, or for 0011 until a completed flash write.
`include "ser_defs.svh"
`default_nettype none
module ser_reporter
  import ser_pkg::*;
#(
  parameter logic [15:0] RD_ADDR_MAX = 16'h0FFF,
  parameter logic [15:0] RD_COUNT_MAX = 16'h0100,
  parameter logic [15:0] WR_ADDR_MAX = 16'h0FFF,
  parameter logic [15:0] WR_COUNT_MAX = 16'h0100,
  parameter int LOG_DEPTH = 16,
  parameter int LOG_AW = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic power_on_i,
  input wire logic err_reset_i,
  input wire logic param_download_i,
  input wire logic [31:0] param_new_i,
  input wire logic rd_start_i,
  input wire ser_xfer_t rd_xfer_i,
  input wire logic rd_data_bad_i,
  input wire logic wr_start_i,
  input wire ser_xfer_t wr_xfer_i,
  input wire logic [15:0] wr_param_size_i,
  input wire logic wr_value_bad_i,
  input wire logic log_corrupt_i,
  input wire logic flash_done_i,
  input wire logic flash_fail_i,
  input wire logic eeprom_fail_i,
  input wire logic [LOG_AW-1:0] log_rd_addr_i,
  output ser_status_t status_o,
  output logic decel_stop_o,
  output logic [31:0] active_param_o,
  output logic log_busy_o,
  output logic [15:0] log_rd_data_o
);
  // ----------------------------------------------------------------
  // fault detection
  // ----------------------------------------------------------------
  logic rd_syntax_bad;
  logic wr_syntax_bad;
  logic rd_addr_bad;
  logic rd_count_bad;
  logic rd_unit_bad;
  logic wr_addr_bad;
  logic wr_count_bad;
  logic wr_size_bad;
  logic wr_unit_bad;
  logic log_fault;
  logic [15:0] next_code;
  logic [31:0] pending_param;
  ser_log_state_t log_state;
  logic [LOG_AW-1:0] clr_addr;
  logic log_wr_en;

  always_comb begin
    rd_addr_bad = rd_xfer_i.addr > RD_ADDR_MAX;
    rd_count_bad = (rd_xfer_i.count == 16'h0000) || (rd_xfer_i.count > RD_COUNT_MAX);
    rd_unit_bad = (rd_xfer_i.count[1:0] & `SER_UNIT_MASK) != 2'h0;
    rd_syntax_bad = rd_start_i && (rd_addr_bad || rd_count_bad || rd_unit_bad); // RL6
    wr_addr_bad = wr_xfer_i.addr > WR_ADDR_MAX;
    wr_count_bad = (wr_xfer_i.count == 16'h0000) || (wr_xfer_i.count > WR_COUNT_MAX);
    // a count that misses the target's size is a count error too
    wr_size_bad = wr_xfer_i.count != wr_param_size_i; // RL8
    wr_unit_bad = (wr_xfer_i.count[1:0] & `SER_UNIT_MASK) != 2'h0;
    wr_syntax_bad = wr_start_i
      && (wr_addr_bad || wr_count_bad || wr_size_bad || wr_unit_bad); // RL7
  end

  assign log_fault = (log_state == SER_CHECK) && log_corrupt_i;

  // lowest code wins when faults coincide
  always_comb begin
    next_code = `SER_CODE_NONE;
    if (param_download_i) begin
      next_code = `SER_CODE_SETUP; // RL1
    end else if (rd_data_bad_i) begin
      next_code = `SER_CODE_DATA; // RL3
    end else if (log_fault) begin
      next_code = `SER_CODE_LOG; // RL4
    end else if (rd_syntax_bad) begin
      next_code = `SER_CODE_RD_SYNTAX; // RL6
    end else if (wr_syntax_bad) begin
      next_code = `SER_CODE_WR_SYNTAX; // RL7
    end else if (wr_start_i && wr_value_bad_i) begin
      next_code = `SER_CODE_WR_DATA; // RL9
    end else if (flash_fail_i) begin
      next_code = `SER_CODE_FLASH; // RL10
    end else if (eeprom_fail_i) begin
      next_code = `SER_CODE_EEPROM; // RL12
    end
  end

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  // a new fault beats a reset in the same cycle so it is never lost
  // a power cycle starts the unit clean, so it clears like an error reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_o <= '0;
    end else if (next_code != `SER_CODE_NONE) begin
      if (!status_o.flag) begin
        status_o.code <= next_code; // RL13
      end
      status_o.flag <= 1'b1; // RL13
    end else if (err_reset_i || power_on_i) begin
      status_o <= '0; // RL14
    end else if (flash_done_i && status_o.code == `SER_CODE_FLASH) begin
      status_o <= '0; // RL11
    end
  end

  // ----------------------------------------------------------------
  // stop request
  // ----------------------------------------------------------------
  // mirrors the flag; kept apart so the stop path reads on its own
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      decel_stop_o <= 1'b0;
    end else if (next_code != `SER_CODE_NONE) begin
      decel_stop_o <= 1'b1; // RL1
    end else if (err_reset_i || power_on_i) begin
      decel_stop_o <= 1'b0; // RL3
    end else if (flash_done_i && status_o.code == `SER_CODE_FLASH) begin
      decel_stop_o <= 1'b0; // RL11
    end
  end

  // ----------------------------------------------------------------
  // parameters: downloaded set waits for the next power cycle
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pending_param <= 32'h00000000;
    end else if (param_download_i) begin
      pending_param <= param_new_i;
    end
  end

  // error reset keeps active set; only the power-on pulse loads the saved one
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      active_param_o <= 32'h00000000;
    end else if (power_on_i) begin
      active_param_o <= pending_param; // RL2
    end
  end

  // ----------------------------------------------------------------
  // error log check and wipe
  // ----------------------------------------------------------------
  // power-on pulses during a wipe are ignored; the log is checked once per power-up
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      log_state <= SER_IDLE;
      clr_addr <= '0;
      log_busy_o <= 1'b0;
    end else begin
      case (log_state)
        SER_IDLE: begin
          if (power_on_i) begin
            log_state <= SER_CHECK; // RL4
          end
        end
        SER_CHECK: begin
          if (log_corrupt_i) begin
            log_state <= SER_INIT; // RL5
            clr_addr <= '0;
            log_busy_o <= 1'b1;
          end else begin
            log_state <= SER_IDLE;
          end
        end
        SER_INIT: begin
          if (clr_addr == LOG_AW'(LOG_DEPTH - 1)) begin
            log_state <= SER_IDLE;
            log_busy_o <= 1'b0;
          end else begin
            clr_addr <= clr_addr + LOG_AW'(`SER_LOG_CLR_CYCLES); // RL5
          end
        end
        default: begin
          log_state <= SER_IDLE;
        end
      endcase
    end
  end

  assign log_wr_en = (log_state == SER_INIT); // RL5

  ser_log_mem #(
    .DEPTH(LOG_DEPTH),
    .AW(LOG_AW)
  ) u_log (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .wr_en_i(log_wr_en),
    .wr_addr_i(clr_addr),
    .wr_data_i(16'h0000),
    .rd_addr_i(log_rd_addr_i),
    .rd_data_o(log_rd_data_o)
  );
endmodule // ser_reporter
`default_nettype wire

/* dv/ser_sva.sv */
// checker for the error reporter's status, stop and parameter outputs
// assumes it is bound to ser_reporter and sees only its ports
`default_nettype none
module ser_sva
  import ser_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic power_on_i,
  input wire logic err_reset_i,
  input wire logic param_download_i,
  input wire logic rd_start_i,
  input wire ser_xfer_t rd_xfer_i,
  input wire logic rd_data_bad_i,
  input wire logic wr_start_i,
  input wire ser_xfer_t wr_xfer_i,
  input wire logic [15:0] wr_param_size_i,
  input wire logic log_corrupt_i,
  input wire logic flash_done_i,
  input wire logic flash_fail_i,
  input wire logic eeprom_fail_i,
  input wire ser_status_t status_o,
  input wire logic decel_stop_o,
  input wire logic [31:0] active_param_o,
  input wire logic log_busy_o
);
  // every fault source but log_corrupt_i idle, so only a log fault can beat a clear
  wire logic quiet = !(power_on_i | param_download_i | rd_start_i | rd_data_bad_i |
    wr_start_i | flash_fail_i | eeprom_fail_i);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_log_bad;
    power_on_i && !status_o.flag ##1 log_corrupt_i && quiet;
  endsequence
  a_flag_stop: assert property (status_o.flag == decel_stop_o)
    else $error("stop differs from flag");
  a_setup_code: assert property (param_download_i && !status_o.flag |=>
    status_o.code == 16'h000B) else $error("setup code wrong");
  a_data_code: assert property (rd_data_bad_i && !status_o.flag && !param_download_i |=>
    status_o.code == 16'h000C) else $error("data code wrong");
  a_rd_units: assert property (rd_start_i && rd_xfer_i.count[1:0] != 2'h0 |=>
    status_o.flag) else $error("read count not refused");
  a_wr_count: assert property (wr_start_i && wr_xfer_i.count != wr_param_size_i |=>
    status_o.flag) else $error("write count not refused");
  a_code_held: assert property (status_o.flag && !err_reset_i && !flash_done_i && !power_on_i
    |=>
    status_o.flag && $stable(status_o.code)) else $error("code not held");
  a_reset_clear: assert property (err_reset_i && quiet && !log_corrupt_i |=>
    !status_o.flag) else $error("reset did not clear");
  a_power_clear: assert property (power_on_i && !log_corrupt_i && !(param_download_i |
    rd_start_i | rd_data_bad_i | wr_start_i | flash_fail_i | eeprom_fail_i) |=>
    !status_o.flag) else $error("power cycle kept error");
  a_flash_clear: assert property (status_o.code == 16'h0011 && flash_done_i && quiet |=>
    !decel_stop_o) else $error("flash error not cleared");
  a_log_wipe: assert property (s_log_bad |=> status_o.code == 16'h000D && log_busy_o)
    else $error("log fault not handled");
  a_params_kept: assert property (param_download_i && !power_on_i |=>
    $stable(active_param_o)) else $error("parameters swapped early");
endmodule // ser_sva
bind ser_reporter ser_sva u_sva (.sys_clk_i, .rst_i, .power_on_i, .err_reset_i,
  .param_download_i, .rd_start_i, .rd_xfer_i, .rd_data_bad_i, .wr_start_i, .wr_xfer_i,
  .wr_param_size_i, .log_corrupt_i, .flash_done_i, .flash_fail_i, .eeprom_fail_i,
  .status_o, .decel_stop_o, .active_param_o, .log_busy_o);
`default_nettype wire

/* dv/ser_host.sv */
// host controller model: bulk transfers and error resets as one-cycle requests
// assumes the reporter samples requests at the next rising edge
`default_nettype none
module ser_host
  import ser_pkg::*;
(
  input wire logic sys_clk_i,
  output logic err_reset_o,
  output logic rd_start_o,
  output ser_xfer_t rd_xfer_o,
  output logic wr_start_o,
  output ser_xfer_t wr_xfer_o,
  output logic [15:0] wr_size_o,
  output logic wr_bad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {err_reset_o, rd_start_o, rd_xfer_o, wr_start_o, wr_xfer_o, wr_size_o, wr_bad_o} = '0;
  end
  // released address, count and size lines show inverted data so a stale value never passes for a live one
  task xfer(input logic wr, input logic [15:0] a, c, s, input logic bad);
    @(posedge sys_clk_i);
    rd_start_o <= !wr;
    wr_start_o <= wr;
    rd_xfer_o <= {a, c};
    wr_xfer_o <= {a, c};
    wr_size_o <= s;
    wr_bad_o <= bad;
    @(posedge sys_clk_i);
    {rd_start_o, wr_start_o} <= 2'h0;
    rd_xfer_o <= ~{a, c};
    wr_xfer_o <= ~{a, c};
    wr_size_o <= ~s;
  endtask
  task clear;
    @(posedge sys_clk_i);
    err_reset_o <= 1'b1;
    @(posedge sys_clk_i);
    err_reset_o <= 1'b0;
  endtask
endmodule // ser_host
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the error reporter, one task per scenario
// assumes ser_host as the far side and ser_sva bound to the design
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ser_pkg::*;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, power_on_i = 1'b0, param_download_i = 1'b0;
  logic rd_data_bad_i = 1'b0, log_corrupt_i = 1'b0, flash_done_i = 1'b0, flash_fail_i = 1'b0;
  logic eeprom_fail_i = 1'b0, err_reset_i, rd_start_i, wr_start_i, wr_value_bad_i;
  logic [31:0] param_new_i = 32'h0;
  logic [3:0] log_rd_addr_i = 4'h0;
  logic [15:0] wr_param_size_i;
  ser_xfer_t rd_xfer_i, wr_xfer_i;
  ser_status_t status_o;
  logic decel_stop_o, log_busy_o;
  logic [31:0] active_param_o;
  logic [15:0] log_rd_data_o;
  int n_fail = 0, checks_done = 0;
  always #4 sys_clk_i = ~sys_clk_i;
  ser_host host (.sys_clk_i, .err_reset_o(err_reset_i), .rd_start_o(rd_start_i),
    .rd_xfer_o(rd_xfer_i), .wr_start_o(wr_start_i), .wr_xfer_o(wr_xfer_i),
    .wr_size_o(wr_param_size_i), .wr_bad_o(wr_value_bad_i));
  ser_reporter uut (.sys_clk_i, .rst_i, .power_on_i, .err_reset_i, .param_download_i,
    .param_new_i, .rd_start_i, .rd_xfer_i, .rd_data_bad_i, .wr_start_i, .wr_xfer_i,
    .wr_param_size_i, .wr_value_bad_i, .log_corrupt_i, .flash_done_i, .flash_fail_i,
    .eeprom_fail_i, .log_rd_addr_i, .status_o, .decel_stop_o, .active_param_o, .log_busy_o,
    .log_rd_data_o);
  // ----
  // shared helpers
  // ----
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task check(input logic ok, input string m);
    checks_done++;
    if (!ok) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task fire(input int k);
    @(posedge sys_clk_i);
    case (k)
      0: flash_fail_i <= 1'b1;
      1: flash_done_i <= 1'b1;
      2: eeprom_fail_i <= 1'b1;
      3: power_on_i <= 1'b1;
      4: param_download_i <= 1'b1;
      default: rd_data_bad_i <= 1'b1;
    endcase
    @(posedge sys_clk_i);
    {flash_fail_i, flash_done_i, eeprom_fail_i, power_on_i, param_download_i} <= 5'h0;
    rd_data_bad_i <= 1'b0;
  endtask
  task expect_code(input logic [15:0] c);
    #1;
    for (int i = 0; i < 4 && status_o.flag !== 1'b1; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
    check(status_o === {1'b1, c} && decel_stop_o === 1'b1, "wrong code or no stop");
    host.clear();
    #1;
    check(status_o === 17'h0 && decel_stop_o === 1'b0, "error not cleared");
  endtask
  // ----
  // scenarios
  // ----
  task t_setup;
    param_new_i <= 32'hA5A5_0001;
    fire(4);
    expect_code(16'h000B);
    check(active_param_o === 32'h0, "parameters swapped early");
    fire(0);
    #1;
    check(status_o === {1'b1, 16'h0011}, "flash code missing");
    fire(3);
    #1;
    check(active_param_o === 32'hA5A5_0001, "parameters not loaded");
    check(status_o === 17'h0 && decel_stop_o === 1'b0, "power cycle kept error");
  endtask
  task t_read;
    host.xfer(1'b0, 16'h0010, 16'h0003, 16'h0, 1'b0);
    expect_code(16'h000E);
    host.xfer(1'b0, 16'h1000, 16'h0004, 16'h0, 1'b0);
    expect_code(16'h000E);
    host.xfer(1'b0, 16'h0010, 16'h0000, 16'h0, 1'b0);
    expect_code(16'h000E);
    host.xfer(1'b0, 16'h0010, 16'h0104, 16'h0, 1'b0);
    expect_code(16'h000E);
    fire(5);
    expect_code(16'h000C);
  endtask
  task t_write;
    host.xfer(1'b1, 16'h1000, 16'h0004, 16'h0004, 1'b0);
    expect_code(16'h000F);
    host.xfer(1'b1, 16'h0020, 16'h0008, 16'h0004, 1'b0);
    expect_code(16'h000F);
    host.xfer(1'b1, 16'h0020, 16'h0004, 16'h0004, 1'b1);
    expect_code(16'h0010);
    host.xfer(1'b1, 16'h0020, 16'h0004, 16'h0004, 1'b0);
    #1;
    check(status_o === 17'h0, "good write refused");
  endtask
  task t_flash;
    fire(0);
    fire(2);
    #1;
    check(status_o === {1'b1, 16'h0011}, "flash code lost");
    fire(1);
    #1;
    check(status_o === 17'h0, "flash error kept");
    fire(2);
    expect_code(16'h0012);
  endtask
  task t_log;
    fire(3);
    log_corrupt_i <= 1'b1;
    @(posedge sys_clk_i);
    log_corrupt_i <= 1'b0;
    log_rd_addr_i <= 4'h1;
    #1;
    check(status_o === {1'b1, 16'h000D} && log_busy_o === 1'b1, "log fault missed");
    for (int i = 0; i < 40 && log_busy_o !== 1'b0; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
    if (log_busy_o !== 1'b0) begin
      n_fail++;
      $display("unexpected at %0t: log wipe never ended", $time);
      conclude();
    end
    @(posedge sys_clk_i);
    #1;
    check(log_rd_data_o === 16'h0, "log record survived");
    expect_code(16'h000D);
  endtask
  initial begin
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_setup();
    t_read();
    t_write();
    t_flash();
    t_log();
    conclude();
  end
endmodule // tb
`default_nettype wire
